// ==== fto_cfg.svh ====
// constants of the flash timeout and status control block
//
// Contract
// RULE_01 - recharge bits weigh 100, 200, 400 mA
// RULE_02 - either kill bit low keeps timeout
// RULE_03 - timeout off only with three conditions
// RULE_04 - status bit 7 shows capacitor ready
// RULE_05 - thermal flag low kills pump, flash, torch
// RULE_06 - status bits 4,3 show short check
// RULE_07 - status bits 1,0 show open check
// RULE_08 - timeout bits weigh 2 to 256 ms
// RULE_09 - timeout resets to 50 ms value
// RULE_10 - pump stops above target, restarts below
// RULE_11 - idle reservoir zero or battery by precharge
// RULE_12 - drain over 2 V flags short, kills
// RULE_13 - drain at 0 V flags open
// RULE_14 - standby drain at vout flags short
// RULE_15 - check results readable in status
// RULE_16 - vout code 200 mV steps from 4.5 V
// RULE_17 - vout returns to 4.5 V on resets
// RULE_18 - each LED enabled independently by host
// RULE_19 - separate current, width, delay per LED
// RULE_20 - trigger pin ignored in shutdown
// RULE_21 - timeout starts with every pulsed flash
// RULE_22 - trigger enable low ignores trigger pin
// RULE_23 - software reset bit zeroes every register
// RULE_24 - expired timeout ends the flash pulse
`ifndef FTO_CFG_SVH
`define FTO_CFG_SVH
// register offsets
`define FTO_OFS_CFG0   8'h01
`define FTO_OFS_CTRL1  8'h02
`define FTO_OFS_PEAK1  8'h03
`define FTO_OFS_PEAK2  8'h04
`define FTO_OFS_DLY1   8'h07
`define FTO_OFS_DLY2   8'h08
`define FTO_OFS_WID1   8'h0A
`define FTO_OFS_WID2   8'h0B
`define FTO_OFS_VOUT   8'h0F
`define FTO_OFS_RECHG  8'h13
`define FTO_OFS_FLASH_TIMEOUT_DURATION   8'h14
`define FTO_OFS_STAT   8'h17
// storage indices
`define FTO_IX_CFG0    4'h0
`define FTO_IX_CTRL1   4'h1
`define FTO_IX_PEAK1   4'h2
`define FTO_IX_DLY1    4'h4
`define FTO_IX_WID1    4'h6
`define FTO_IX_VOUT    4'h8
`define FTO_IX_RECHG   4'h9
`define FTO_IX_FLASH_TIMEOUT_DURATION    4'hA
`define FTO_IX_STAT    4'hB
`define FTO_IX_NONE    4'hF
`define FTO_NREGS      11
// reset values
`define FTO_RST_ZERO   8'h00
`define FTO_RST_FLASH_TIMEOUT_DURATION   8'h19
// field positions
`define FTO_B_CHECK    4
`define FTO_B_SWRST    7
`define FTO_B_PUMPFL   6
`define FTO_B_FLMODE   5
`define FTO_B_I2CTRG   4
`define FTO_B_EXTTRG   3
`define FTO_B_PUMP     2
`define FTO_B_PRECH    1
`define FTO_B_KILLB    7
`define FTO_B_KILLA    6
// scaling and timing
`define FTO_CLK_KHZ    40000
`define FTO_TICK_MS    1
`define FTO_FLASH_TIMEOUT_DURATION_LSB   10'd2
`define FTO_DLY_LSB    10'd2
`define FTO_PEAK_LIM   8'h05
`define FTO_VOUT_BASE  13'd4500
`define FTO_VOUT_STEP  13'd200
`define FTO_VOUT_MAXC  3'd5
`define FTO_RECHG_LSB  10'd100
`define FTO_I2C_DEV    7'h3E
`endif

// ==== fto_pkg.sv ====
// types of the flash timeout and status control block
package fto_pkg;
	typedef logic [7:0] fto_byte_t;
	typedef enum logic [1:0] {FL_IDLE, FL_I2C, FL_EXT} fto_flash_e;
	typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_REG, I2_WDATA, I2_RDATA} fto_i2c_e;
endpackage

// ==== fto_reg_if.sv ====
// register access carrier between serial port and register file
`timescale 1ns/1ps
`default_nettype none
interface fto_reg_if;
	logic              wr;
	fto_pkg::fto_byte_t addr;
	fto_pkg::fto_byte_t wdata;
	fto_pkg::fto_byte_t rdata;
	modport link (output wr, output addr, output wdata, input rdata);
	modport regs (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== fto_i2c_slave.sv ====
// serial two-wire register port
`timescale 1ns/1ps
`default_nettype none
`include "fto_cfg.svh"
module fto_i2c_slave (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// pins
	input  wire logic scl,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	// register side
	fto_reg_if.link   bus
);
	import fto_pkg::*;

	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [1:0] s3_q;
	fto_i2c_e   st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	fto_byte_t  sh_q, sh_d;
	fto_byte_t  ptr_q, ptr_d;
	logic       oe_q, oe_d;
	logic       wr_q, wr_d;
	logic       scl_r, scl_f, start, stop, sda_s;

	assign sda_s = s2_q[0];
	assign scl_r = s2_q[1] & ~s3_q[1];
	assign scl_f = ~s2_q[1] & s3_q[1];
	assign start = s2_q[1] & s3_q[1] & ~s2_q[0] & s3_q[0];
	assign stop  = s2_q[1] & s3_q[1] & s2_q[0] & ~s3_q[0];
	assign bus.wr    = wr_q;
	assign bus.addr  = ptr_q;
	assign bus.wdata = sh_q;
	assign sda_oe    = oe_q;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		wr_d = 1'b0;
		if (start) begin
			st_d = I2_ADDR;
			// first scl fall after start wraps count to zero
			cnt_d = 4'hF;
			oe_d = 1'b0;
		end else if (stop) begin
			st_d = I2_IDLE;
			oe_d = 1'b0;
		end else if (st_q != I2_IDLE) begin
			if (scl_r && cnt_q < 4'h8)
				sh_d = {sh_q[6:0], sda_s};
			if (scl_r && cnt_q == 4'h8 && st_q == I2_RDATA && sda_s)
				st_d = I2_IDLE;
			if (scl_f) begin
				if (cnt_q == 4'h7) begin
					// ninth clock: acknowledge slot
					cnt_d = 4'h8;
					case (st_q)
						I2_ADDR:  oe_d = (sh_q[7:1] == `FTO_I2C_DEV);
						I2_REG: begin
							oe_d = 1'b1;
							ptr_d = sh_q;
						end
						I2_WDATA: begin
							oe_d = 1'b1;
							wr_d = 1'b1;
						end
						I2_RDATA: begin
							oe_d = 1'b0;
							ptr_d = ptr_q + 8'h01;
						end
						default: oe_d = 1'b0;
					endcase
				end else if (cnt_q == 4'h8) begin
					cnt_d = 4'h0;
					oe_d = 1'b0;
					case (st_q)
						I2_ADDR: begin
							if (!oe_q) begin
								st_d = I2_IDLE;
							end else if (sh_q[0]) begin
								st_d = I2_RDATA;
								sh_d = bus.rdata;
								oe_d = ~bus.rdata[7];
							end else begin
								st_d = I2_REG;
							end
						end
						I2_REG:   st_d = I2_WDATA;
						I2_WDATA: ptr_d = ptr_q + 8'h01;
						I2_RDATA: begin
							sh_d = bus.rdata;
							oe_d = ~bus.rdata[7];
						end
						default: st_d = I2_IDLE;
					endcase
				end else begin
					cnt_d = cnt_q + 4'h1;
					if (st_q == I2_RDATA)
						oe_d = ~sh_q[7];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h3;
			st_q <= I2_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			s1_q <= {scl, sda_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
			sda_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== fto_flash_ctrl.sv ====
// flash timeout, status and charge pump control, top level
`timescale 1ns/1ps
`default_nettype none
`include "fto_cfg.svh"
module fto_flash_ctrl #(
	parameter int TICK_CYC = `FTO_CLK_KHZ * `FTO_TICK_MS
) (
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst_n,
	// serial port
	input  wire logic  scl,
	input  wire logic  sda_i,
	output logic       sda_o,
	output logic       sda_oe,
	// trigger and analog sense
	input  wire logic  flash_trigger_pin,
	input  wire logic  cap_ready,
	input  wire logic  thermal_hot,
	input  wire logic  vout_high,
	input  wire logic [1:0] drain_zero,
	input  wire logic [1:0] drain_at_vout,
	input  wire logic [1:0] drain_over_2v,
	// power stage controls
	output logic       pump_en,
	output logic       precharge_en,
	output logic       torch_en,
	output logic       flash_active,
	output logic       timeout_armed,
	output logic       check_fault,
	output logic [1:0] led_gate,
	output logic [12:0] vout_mv,
	output logic [9:0] recharge_ma,
	output fto_pkg::fto_byte_t flash_current_led1,
	output fto_pkg::fto_byte_t flash_current_led2
);
	import fto_pkg::*;

	localparam int TW = $clog2(TICK_CYC + 1);

	function automatic logic [3:0] reg_idx(input fto_byte_t a);
		case (a)
			`FTO_OFS_CFG0:  reg_idx = `FTO_IX_CFG0;
			`FTO_OFS_CTRL1: reg_idx = `FTO_IX_CTRL1;
			`FTO_OFS_PEAK1: reg_idx = `FTO_IX_PEAK1;
			`FTO_OFS_PEAK2: reg_idx = `FTO_IX_PEAK1 + 4'h1;
			`FTO_OFS_DLY1:  reg_idx = `FTO_IX_DLY1;
			`FTO_OFS_DLY2:  reg_idx = `FTO_IX_DLY1 + 4'h1;
			`FTO_OFS_WID1:  reg_idx = `FTO_IX_WID1;
			`FTO_OFS_WID2:  reg_idx = `FTO_IX_WID1 + 4'h1;
			`FTO_OFS_VOUT:  reg_idx = `FTO_IX_VOUT;
			`FTO_OFS_RECHG: reg_idx = `FTO_IX_RECHG;
			`FTO_OFS_FLASH_TIMEOUT_DURATION:  reg_idx = `FTO_IX_FLASH_TIMEOUT_DURATION;
			`FTO_OFS_STAT:  reg_idx = `FTO_IX_STAT;
			default:        reg_idx = `FTO_IX_NONE;
		endcase
	endfunction

	fto_reg_if bus ();

	fto_i2c_slave u_port (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.scl     (scl),
		.sda_i   (sda_i),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe),
		.bus     (bus)
	);

	// ******************************
	// input synchronisers
	// ******************************
	logic [9:0] s1_q, s2_q;
	logic       trig_s, cap_s, hot_s, vhigh_s;
	logic [1:0] zero_s, atv_s, over_s;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_q <= 10'h000;
			s2_q <= 10'h000;
		end else begin
			s1_q <= {flash_trigger_pin, cap_ready, thermal_hot, vout_high,
				drain_zero, drain_at_vout, drain_over_2v};
			s2_q <= s1_q;
		end
	end
	assign {trig_s, cap_s, hot_s, vhigh_s, zero_s, atv_s, over_s} = s2_q;

	// ******************************
	// register file
	// ******************************
	fto_byte_t  regs_q [`FTO_NREGS];
	fto_byte_t  regs_d [`FTO_NREGS];
	fto_byte_t  cfg0, ctrl1, rechg, flash_timeout_duration, stat;
	logic [3:0] wr_ix, rd_ix;
	logic       swrst, done_clr;

	assign cfg0  = regs_q[`FTO_IX_CFG0];
	assign ctrl1 = regs_q[`FTO_IX_CTRL1];
	assign rechg = regs_q[`FTO_IX_RECHG];
	assign flash_timeout_duration  = regs_q[`FTO_IX_FLASH_TIMEOUT_DURATION];
	assign wr_ix = reg_idx(bus.addr);
	assign rd_ix = reg_idx(bus.addr);
	assign swrst = bus.wr & (wr_ix == `FTO_IX_CTRL1) & bus.wdata[`FTO_B_SWRST];
	assign flash_current_led1 = regs_q[`FTO_IX_PEAK1];      // see RULE_19
	assign flash_current_led2 = regs_q[`FTO_IX_PEAK1 + 1];  // see RULE_19

	always_comb begin
		regs_d = regs_q;
		if (done_clr)
			regs_d[`FTO_IX_CTRL1][`FTO_B_I2CTRG] = 1'b0;
		if (bus.wr && wr_ix < `FTO_IX_STAT)
			regs_d[wr_ix] = bus.wdata;
		if (swrst)
			regs_d = '{default: `FTO_RST_ZERO};  // see RULE_23
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			regs_q <= '{default: `FTO_RST_ZERO};  // see RULE_17
			regs_q[`FTO_IX_FLASH_TIMEOUT_DURATION] <= `FTO_RST_FLASH_TIMEOUT_DURATION;  // see RULE_09
		end else begin
			regs_q <= regs_d;
		end
	end

	// read mux, status is live state
	always_comb begin
		if (rd_ix == `FTO_IX_STAT)
			bus.rdata = stat;  // see RULE_15
		else if (rd_ix < `FTO_IX_STAT)
			bus.rdata = regs_q[rd_ix];
		else
			bus.rdata = 8'h00;
	end

	// ******************************
	// flash sequencer and timeout
	// ******************************
	fto_flash_e fl_q, fl_d;
	logic [TW-1:0] tick_q, tick_d;
	logic [9:0] ms_q, ms_d, end_max;
	logic [9:0] led_end [2];
	logic       i2c_prev_q, ext_prev_q, fault_q, fault_d;
	logic       active, thermal_ok, run_ok, flash_timeout_duration_en, flash_timeout_duration_hit;
	logic [1:0] led_en, short_ok, open_ok;

	assign active     = ctrl1[`FTO_B_PUMP] | ctrl1[`FTO_B_PRECH];
	assign thermal_ok = ~hot_s;
	assign led_en     = cfg0[1:0];  // see RULE_18
	assign run_ok     = active & ctrl1[`FTO_B_FLMODE] & thermal_ok & ~fault_q;  // see RULE_05
	// timeout dropped only when all three conditions meet
	assign flash_timeout_duration_en = ~(rechg[`FTO_B_KILLB] & rechg[`FTO_B_KILLA]  // see RULE_02
		& ctrl1[`FTO_B_EXTTRG]
		& (regs_q[`FTO_IX_PEAK1] <= `FTO_PEAK_LIM)
		& (regs_q[`FTO_IX_PEAK1 + 1] <= `FTO_PEAK_LIM));  // see RULE_03
	assign flash_timeout_duration_hit = flash_timeout_duration_en & (ms_q >= 10'(flash_timeout_duration) * `FTO_FLASH_TIMEOUT_DURATION_LSB);  // see RULE_08
	assign end_max  = (led_end[0] > led_end[1]) ? led_end[0] : led_end[1];
	assign stat = {cap_s, thermal_ok, 1'b0, short_ok, 1'b0, open_ok};  // see RULE_04

	always_comb begin
		fl_d = fl_q;
		tick_d = tick_q;
		ms_d = ms_q;
		done_clr = 1'b0;
		fault_d = fault_q;
		if (cfg0[`FTO_B_CHECK] && fl_q != FL_IDLE && |(over_s & led_en))
			fault_d = 1'b1;  // see RULE_12
		// elapsed time in ms, cleared while idle so timeout restarts
		if (tick_q == TW'(TICK_CYC - 1)) begin
			tick_d = '0;
			ms_d = ms_q + 10'd1;
		end else begin
			tick_d = tick_q + TW'(1);
		end
		case (fl_q)
			FL_IDLE: begin
				tick_d = '0;
				ms_d = 10'd0;  // see RULE_21
				if (run_ok && ctrl1[`FTO_B_EXTTRG] && trig_s && !ext_prev_q)
					fl_d = FL_EXT;  // see RULE_20
				else if (run_ok && !ctrl1[`FTO_B_EXTTRG]  // see RULE_22
					&& ctrl1[`FTO_B_I2CTRG] && !i2c_prev_q)
					fl_d = FL_I2C;
			end
			FL_I2C: begin
				if (!run_ok || flash_timeout_duration_hit || !ctrl1[`FTO_B_I2CTRG]  // see RULE_24
					|| ms_q >= end_max) begin
					fl_d = FL_IDLE;
					done_clr = 1'b1;
				end
			end
			FL_EXT: begin
				if (!run_ok || flash_timeout_duration_hit || !trig_s || !ctrl1[`FTO_B_EXTTRG])
					fl_d = FL_IDLE;  // see RULE_24
			end
			default: fl_d = FL_IDLE;
		endcase
		if (swrst) begin
			fl_d = FL_IDLE;
			fault_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fl_q <= FL_IDLE;
			tick_q <= '0;
			ms_q <= 10'd0;
			fault_q <= 1'b0;
			i2c_prev_q <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			fl_q <= fl_d;
			tick_q <= tick_d;
			ms_q <= ms_d;
			fault_q <= fault_d;
			i2c_prev_q <= ctrl1[`FTO_B_I2CTRG];
			ext_prev_q <= trig_s;
		end
	end

	// ******************************
	// per LED gate and check
	// ******************************
	for (genvar i = 0; i < 2; i++) begin : g_led
		logic [9:0] t_on, t_off;
		logic       gt_q, gt_d, sh_q, sh_d, op_q, op_d;

		assign t_on  = 10'(regs_q[`FTO_IX_DLY1 + i]) * `FTO_DLY_LSB;  // see RULE_19
		assign t_off = t_on + 10'(regs_q[`FTO_IX_WID1 + i]);
		assign led_end[i] = led_en[i] ? t_off : 10'd0;
		assign led_gate[i] = gt_q;
		assign short_ok[i] = sh_q;
		assign open_ok[i]  = op_q;

		always_comb begin
			gt_d = led_en[i] & ((fl_d == FL_EXT)
				| ((fl_d == FL_I2C) & (ms_q >= t_on) & (ms_q < t_off)));  // see RULE_18
			sh_d = sh_q;
			op_d = op_q;
			if (cfg0[`FTO_B_CHECK]) begin
				if (fl_q == FL_IDLE) begin
					op_d = ~zero_s[i];  // see RULE_13
					sh_d = ~atv_s[i];  // see RULE_14
				end else begin
					if (zero_s[i])
						op_d = 1'b0;  // see RULE_07
					if (over_s[i])
						sh_d = 1'b0;  // see RULE_06
				end
			end
			if (swrst) begin
				sh_d = 1'b1;
				op_d = 1'b1;
			end
		end

		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				gt_q <= 1'b0;
				sh_q <= 1'b1;
				op_q <= 1'b1;
			end else begin
				gt_q <= gt_d;
				sh_q <= sh_d;
				op_q <= op_d;
			end
		end
	end

	// ******************************
	// pump, precharge and scaling
	// ******************************
	logic        pump_d, prech_d, torch_d;
	logic [12:0] vmv_d;
	logic [9:0]  rma_d;
	logic [2:0]  vcode;

	always_comb begin
		pump_d = ctrl1[`FTO_B_PUMP] & thermal_ok & ~fault_q & ~vhigh_s  // see RULE_10
			& ((fl_q == FL_IDLE) | ctrl1[`FTO_B_PUMPFL]);
		prech_d = ctrl1[`FTO_B_PRECH] & ~ctrl1[`FTO_B_PUMP];  // see RULE_11
		torch_d = active & ~ctrl1[`FTO_B_FLMODE] & thermal_ok & |led_en;
		vcode = regs_q[`FTO_IX_VOUT][2:0];
		if (vcode > `FTO_VOUT_MAXC)
			vcode = `FTO_VOUT_MAXC;
		vmv_d = `FTO_VOUT_BASE + 13'(vcode) * `FTO_VOUT_STEP;  // see RULE_16
		rma_d = 10'(rechg[2:0]) * `FTO_RECHG_LSB;  // see RULE_01
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pump_en <= 1'b0;
			precharge_en <= 1'b0;
			torch_en <= 1'b0;
			flash_active <= 1'b0;
			timeout_armed <= 1'b0;
			check_fault <= 1'b0;
			vout_mv <= `FTO_VOUT_BASE;
			recharge_ma <= 10'd0;
		end else begin
			pump_en <= pump_d;
			precharge_en <= prech_d;
			torch_en <= torch_d;
			flash_active <= (fl_d != FL_IDLE);
			timeout_armed <= flash_timeout_duration_en & (fl_d != FL_IDLE);
			check_fault <= fault_q;
			vout_mv <= vmv_d;
			recharge_ma <= rma_d;
		end
	end

	// ******************************
	// assertions
	// ******************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	recharge_map_a: assert property (##1 recharge_ma == $past(10'(rechg[2:0])) * 10'd100) // see RULE_01
		else $error("recharge current scaling wrong");
	kill_keeps_a: assert property (!(rechg[7] & rechg[6]) |-> flash_timeout_duration_en) // see RULE_02
		else $error("timeout dropped with a kill bit low");
	no_timeout_a: assert property (!flash_timeout_duration_en && fl_q == FL_EXT && !swrst // see RULE_03
		&& ms_q > 10'(flash_timeout_duration) * 10'd2 && trig_s && run_ok && ctrl1[3] |=> fl_q == FL_EXT)
		else $error("flash ended by disabled timeout");
	ready_bit_a: assert property (rd_ix == 4'hB |-> bus.rdata[7] == cap_s) // see RULE_04
		else $error("ready bit not shown");
	thermal_kill_a: assert property (hot_s |=> !pump_en && !torch_en // see RULE_05
		&& led_gate == 2'b00 && !flash_active)
		else $error("power blocks live while hot");
	standby_short_a: assert property (cfg0[4] && fl_q == FL_IDLE && atv_s[0] // see RULE_14
		&& !swrst |=> !short_ok[0] && stat[3] == 1'b0)
		else $error("standby short not flagged");
	over_kill_a: assert property (cfg0[4] && |(over_s & led_en) // see RULE_12
		&& fl_q != FL_IDLE && !swrst |=> fault_q ##1 !pump_en && fl_q == FL_IDLE)
		else $error("overvoltage drain not handled");
	vout_map_a: assert property (regs_q[8][2:0] == 3'd0 |=> vout_mv == 13'd4500) // see RULE_16
		else $error("vout base code wrong");
	flash_timeout_duration_reset_a: assert property (disable iff (1'b0) !rst_n |=> flash_timeout_duration == 8'h19) // see RULE_09
		else $error("timeout reset value wrong");
	shutdown_a: assert property (!active && fl_q == FL_IDLE |=> fl_q == FL_IDLE) // see RULE_20
		else $error("flash started in shutdown");
	pump_hyst_a: assert property (vhigh_s |=> !pump_en) // see RULE_10
		else $error("pump running above target");
	timeout_end_a: assert property (fl_q != FL_IDLE && flash_timeout_duration_hit |=> fl_q == FL_IDLE ##1 !flash_active) // see RULE_24
		else $error("flash outlived timeout");

	ext_flash_c: cover property (fl_q == FL_IDLE ##1 fl_q == FL_EXT);
	i2c_done_c: cover property (fl_q == FL_I2C && done_clr && !flash_timeout_duration_hit);
	flash_timeout_duration_hit_c: cover property (fl_q != FL_IDLE && flash_timeout_duration_hit);
	fault_c: cover property (!fault_q ##1 fault_q);
endmodule
`default_nettype wire

// ==== fto_host_model.sv ====
// serial host and trigger source model facing the flash control block
`timescale 1ns/1ps
`default_nettype none
module fto_host_model (
	// clock
	input  wire logic ref_clk,
	// serial pins, open drain with pull-up
	output var logic  scl,
	output logic      sda_i,
	input  wire logic sda_oe,
	// trigger source
	output var logic  flash_trigger_pin
);
	logic host_low;

	// wired level of the pulled-up data line
	assign sda_i = ~(host_low | sda_oe);

	initial begin
		scl = 1'b1;
		host_low = 1'b0;
		flash_trigger_pin = 1'b0;
	end

	// one phase of 8 clocks, pins change just after an edge
	task automatic set(input logic c, input logic lo);
		@(posedge ref_clk);
		scl <= c;
		host_low <= lo;
		repeat (7) @(posedge ref_clk);
	endtask

	// data changes only while the clock line is low
	task automatic bit_out(input logic v);
		set(1'b0, host_low);
		set(1'b0, ~v);
		set(1'b1, ~v);
	endtask

	task automatic start();
		set(1'b0, 1'b0);
		set(1'b1, 1'b0);
		set(1'b1, 1'b1);
	endtask

	task automatic stop();
		set(1'b0, 1'b1);
		set(1'b1, 1'b1);
		set(1'b1, 1'b0);
	endtask

	// eight bits msb first, then line released for the acknowledge
	task automatic byte_out(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		bit_out(1'b1);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		start();
		byte_out(8'h7C);
		byte_out(a);
		byte_out(d);
		stop();
	endtask

	// pointer write, repeated start, one byte read, then no-ack
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		start();
		byte_out(8'h7C);
		byte_out(a);
		start();
		byte_out(8'h7D);
		for (int i = 0; i < 8; i++) begin
			bit_out(1'b1);
			d = {d[6:0], sda_i};
		end
		bit_out(1'b1);
		stop();
	endtask

	task automatic trig(input logic v);
		@(posedge ref_clk);
		flash_trigger_pin <= v;
	endtask
endmodule
`default_nettype wire

// ==== flash_timeout_status_control_tb_top.sv ====
// self-checking bench of the flash timeout and status control block
`timescale 1ns/1ps
`default_nettype none
module flash_timeout_status_control_tb_top;
	import fto_pkg::*;
	logic               ref_clk;
	logic               rst_n;
	logic               scl;
	logic               sda_i;
	logic               sda_o;
	logic               sda_oe;
	logic               flash_trigger_pin;
	logic               cap_ready;
	logic               thermal_hot;
	logic               vout_high;
	logic [1:0]         drain_zero;
	logic [1:0]         drain_at_vout;
	logic [1:0]         drain_over_2v;
	logic               pump_en;
	logic               precharge_en;
	logic               torch_en;
	logic               flash_active;
	logic               timeout_armed;
	logic               check_fault;
	logic [1:0]         led_gate;
	logic [12:0]        vout_mv;
	logic [9:0]         recharge_ma;
	fto_byte_t          flash_current_led1;
	fto_byte_t          flash_current_led2;
	fto_byte_t          v;
	int                 bad_count = 0;
	int                 checks_done = 0;
	int                 act_cnt = 0;

	fto_flash_ctrl #(.TICK_CYC(40)) u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe(sda_oe), .flash_trigger_pin(flash_trigger_pin), .cap_ready(cap_ready),
		.thermal_hot(thermal_hot), .vout_high(vout_high), .drain_zero(drain_zero),
		.drain_at_vout(drain_at_vout), .drain_over_2v(drain_over_2v), .pump_en(pump_en),
		.precharge_en(precharge_en), .torch_en(torch_en), .flash_active(flash_active),
		.timeout_armed(timeout_armed), .check_fault(check_fault), .led_gate(led_gate),
		.vout_mv(vout_mv), .recharge_ma(recharge_ma),
		.flash_current_led1(flash_current_led1), .flash_current_led2(flash_current_led2));

	fto_host_model u_host (
		.ref_clk(ref_clk), .scl(scl), .sda_i(sda_i), .sda_oe(sda_oe),
		.flash_trigger_pin(flash_trigger_pin));

	always #12.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		if (flash_active === 1'b1)
			act_cnt++;
	end

	// ****************************************
	// checking helpers
	// ****************************************
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] e);
		checks_done++;
		if (seen !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, seen);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string n);
		logic [7:0] d;
		u_host.reg_read(a, d);
		check(n, {8'h00, d}, e);
	endtask

	function automatic logic [15:0] exp_rechg(input logic [7:0] r);
		return (r[2] ? 16'd400 : 16'd0) + (r[1] ? 16'd200 : 16'd0) + (r[0] ? 16'd100 : 16'd0);
	endfunction

	function automatic logic [15:0] exp_vout(input logic [2:0] c);
		return 16'd4500 + 16'd200 * ((c > 3'd5) ? 16'd5 : {13'h0000, c});
	endfunction

	function automatic logic [15:0] exp_stat();
		return {8'h00, cap_ready, ~thermal_hot, 1'b0, ~drain_at_vout, 1'b0, ~drain_zero};
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		void'($urandom(78));
		{cap_ready, vout_high, drain_zero, drain_at_vout} = 6'($urandom);
		thermal_hot = 1'b0;
		drain_over_2v = 2'b00;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check("vout reset", vout_mv, 16'd4500);
		check("sda drive", sda_o, 1'b0);
		rd_chk(8'h14, 16'h0019, "flash_timeout_duration reset");
		rd_chk(8'h13, 16'h0000, "rechg reset");
		rd_chk(8'h17, {8'h00, cap_ready, 7'h5B}, "stat reset");
		rd_chk(8'h20, 16'h0000, "unmapped");
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'h07 : 8'($urandom) & 8'hC7;
			u_host.reg_write(8'h13, v);
			check("rechg ma", recharge_ma, exp_rechg(v));
			rd_chk(8'h13, {8'h00, v}, "rechg rd");
		end
		for (int c = 0; c < 8; c++) begin
			u_host.reg_write(8'h0F, 8'(c));
			check("vout mv", vout_mv, exp_vout(3'(c)));
		end
		u_host.reg_write(8'h02, 8'h02);
		check("prech on", precharge_en, 1'b1);
		u_host.reg_write(8'h01, 8'h11);
		u_host.reg_write(8'h02, 8'h06);
		check("prech off", precharge_en, 1'b0);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			{cap_ready, thermal_hot, vout_high} <= 3'($urandom);
			{drain_zero, drain_at_vout} <= 4'($urandom);
			drain_over_2v <= 2'($urandom);
			repeat (6) @(posedge ref_clk);
			check("pump", pump_en, !thermal_hot && !vout_high);
			check("torch", torch_en, !thermal_hot);
			rd_chk(8'h17, exp_stat(), "status");
		end
		@(posedge ref_clk);
		{cap_ready, vout_high, drain_zero, drain_at_vout} <= 6'($urandom);
		{thermal_hot, drain_over_2v} <= 3'b000;
		for (int i = 0; i < 2; i++) begin
			u_host.reg_write(8'h02, (i == 1) ? 8'h24 : 8'h28);
			u_host.trig(1'b1);
			repeat (20) @(posedge ref_clk);
			check("no flash", flash_active, 1'b0);
			u_host.trig(1'b0);
		end
		u_host.reg_write(8'h01, 8'h02);
		u_host.reg_write(8'h0B, 8'hFF);
		u_host.reg_write(8'h14, 8'h02);
		act_cnt = 0;
		u_host.reg_write(8'h02, 8'h34);
		check("gate", led_gate, 2'b10);
		check("armed", timeout_armed, 1'b1);
		repeat (300) @(posedge ref_clk);
		check("flash_timeout_duration len", act_cnt inside {[150:170]}, 1'b1);
		rd_chk(8'h02, 16'h0024, "trg clear");
		u_host.reg_write(8'h02, 8'h2C);
		for (int i = 0; i < 3; i++) begin
			u_host.reg_write(8'h13, (i == 1) ? 8'h80 : 8'hC0);
			u_host.reg_write(8'h03, (i == 2) ? 8'h06 : 8'h00);
			u_host.trig(1'b1);
			repeat (20) @(posedge ref_clk);
			check("ext armed", timeout_armed, i > 0);
			repeat (280) @(posedge ref_clk);
			check("ext run", flash_active, i == 0);
			u_host.trig(1'b0);
			repeat (4) @(posedge ref_clk);
		end
		check("peak1", flash_current_led1, 8'h06);
		v = 8'($urandom);
		u_host.reg_write(8'h04, v);
		check("peak2", flash_current_led2, {8'h00, v});
		u_host.reg_write(8'h01, 8'h12);
		u_host.trig(1'b1);
		repeat (10) @(posedge ref_clk);
		drain_over_2v <= 2'b10;
		repeat (8) @(posedge ref_clk);
		check("fault", check_fault, 1'b1);
		check("fault pump", pump_en, 1'b0);
		check("fault gate", led_gate, 2'b00);
		u_host.trig(1'b0);
		drain_over_2v <= 2'b00;
		u_host.reg_write(8'h02, 8'h80);
		check("sr vout", vout_mv, 16'd4500);
		check("sr fault", check_fault, 1'b0);
		rd_chk(8'h14, 16'h0000, "sr flash_timeout_duration");
		final_report();
	end
endmodule
`default_nettype wire
